// >>> core/eil_top.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - reset gives edge-only sensitivity; mode bit selects edge plus level
// - vector fetch acknowledge clears the request latch
// - writing one to acknowledge bit clears the request latch
// - reset clears the request latch
// - edge mode: latch holds until fetch, acknowledge or reset
// - level mode: clears only after acknowledge and pin high
// - level mode: acknowledge and pin return in any order
// - reset clears latch and mode bit even with pin low
// - mask bit withholds the request from priority logic
// - cpu global interrupt mask also blocks the request
// - pending flag reads pending state regardless of mask bit
// - acknowledge bit always reads zero
// - mask bit written one disables; reset clears it
module eil_top (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              irq_pin_n,
  input  wire logic              vector_fetch_ack,
  input  wire logic              cpu_global_mask,
  output logic                   cpu_irq_request,
  output logic                   pin_level,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire eil_pkg::eil_addr_t paddr,
  input  wire eil_pkg::eil_word_t pwdata,
  output eil_pkg::eil_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq
);
  import eil_pkg::*;

  logic    fall;
  logic    latch;
  logic    ack_seen;
  logic    mode;
  logic    ext_int_mask_bit;
  eil_ev_t ev_status;
  eil_ev_t ev_mask;
  eil_word_t rdata;

  // ****************************************************************
  // pin conditioning
  // ****************************************************************
  eil_edge_sync u_sync (
    .mclk      (mclk),
    .reset     (reset),
    .pin_n     (irq_pin_n),
    .pin_level (pin_level),
    .fall      (fall)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd       = access & ~pwrite;
  wire hit_ctrl = (paddr == `EIL_STATUS_CONTROL_ADDR);
  wire hit_stat = (paddr == `EIL_IRQ_STATUS_ADDR);
  wire hit_mask = (paddr == `EIL_IRQ_MASK_ADDR);
  wire hit_any  = hit_ctrl | hit_stat | hit_mask;
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_mask  = wr & hit_mask;
  wire rd_stat  = rd & hit_stat;
  wire sw_ack   = wr_ctrl & pwdata[`EIL_ACK_BIT];
  wire any_ack  = sw_ack | vector_fetch_ack;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // ****************************************************************
  // request latch
  // ****************************************************************
  // level mode: an acknowledge is remembered until the pin is high
  wire ack_eff  = any_ack | ack_seen;
  wire clr_edge = any_ack;
  wire clr_lvl  = ack_eff & pin_level;
  wire clr      = mode ? clr_lvl : clr_edge;
  // a new edge wins over a clear in the same cycle
  wire next_latch = fall | (latch & ~clr);
  wire next_ack_seen = mode & latch & ~fall & ack_eff & ~pin_level;

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch    <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      latch    <= next_latch;
      ack_seen <= next_ack_seen;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode             <= 1'b0;
      ext_int_mask_bit <= 1'b0;
    end else if (wr_ctrl) begin
      mode             <= pwdata[`EIL_MODE_BIT];
      ext_int_mask_bit <= pwdata[`EIL_MASK_BIT];
    end
  end

  // ****************************************************************
  // cpu request
  // ****************************************************************
  wire pending_flag = latch;
  assign cpu_irq_request = latch & ~ext_int_mask_bit & ~cpu_global_mask;

  // ****************************************************************
  // event status, mask and interrupt line
  // ****************************************************************
  wire [`EIL_EV_W-1:0] ev_set = {any_ack & latch, fall};
  // set wins over the clear-on-read
  wire [`EIL_EV_W-1:0] next_ev = ev_set | (rd_stat ? `EIL_EV_RESET : ev_status);

  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_status <= `EIL_EV_RESET;
      ev_mask   <= `EIL_EV_RESET;
    end else begin
      ev_status <= next_ev;
      if (wr_mask) begin
        ev_mask <= pwdata[`EIL_EV_W-1:0];
      end
    end
  end

  assign irq = |(ev_status & ev_mask);

  // ****************************************************************
  // read mux
  // ****************************************************************
  // acknowledge bit position left at zero on purpose
  wire [31:0] rd_ctrl = {28'h0, pending_flag, 1'b0, ext_int_mask_bit, mode};
  wire [31:0] rd_ev   = {30'h0, ev_status};
  wire [31:0] rd_msk  = {30'h0, ev_mask};
  wire [31:0] rd_sel  = hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_ev :
                        hit_mask ? rd_msk : 32'h0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      rdata <= rd_sel;
    end
  end

  assign prdata = rdata;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_edge_sets;
    @(posedge mclk) disable iff (reset) fall |=> latch;
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set latch");

  property p_fetch_clears;
    @(posedge mclk) disable iff (reset)
      (!mode && vector_fetch_ack && !fall) |=> !latch;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears)
    else $error("vector fetch did not clear latch");

  property p_sw_clears;
    @(posedge mclk) disable iff (reset)
      (!mode && sw_ack && !fall) |=> !latch;
  endproperty
  a_sw_clears: assert property (p_sw_clears)
    else $error("software ack did not clear latch");

  property p_reset_clears;
    @(posedge mclk) reset |=> !latch && !mode && !ext_int_mask_bit;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left state set");

  property p_edge_hold;
    @(posedge mclk) disable iff (reset)
      (latch && !mode && !any_ack) |=> latch;
  endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("latch dropped without clear");

  property p_level_hold;
    @(posedge mclk) disable iff (reset)
      (latch && mode && !pin_level) |=> latch;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("latch dropped while pin low");

  property p_late_pin;
    @(posedge mclk) disable iff (reset)
      (latch && mode && any_ack && !pin_level && !fall ##1 mode && pin_level
       && !fall) |=> !latch;
  endproperty
  a_late_pin: assert property (p_late_pin)
    else $error("pin return after ack did not clear");

  property p_mask;
    @(posedge mclk) disable iff (reset)
      cpu_irq_request |-> latch && !ext_int_mask_bit && !cpu_global_mask;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked request presented");

  property p_global;
    @(posedge mclk) disable iff (reset)
      cpu_global_mask |-> !cpu_irq_request;
  endproperty
  a_global: assert property (p_global)
    else $error("global mask ignored");

  property p_ack_zero;
    @(posedge mclk) disable iff (reset)
      (access && hit_ctrl && !pwrite) |-> !prdata[`EIL_ACK_BIT]
        && prdata[`EIL_PEND_BIT] == $past(latch);
  endproperty
  a_ack_zero: assert property (p_ack_zero)
    else $error("ack reads one or pending wrong");

  c_edge_mode: cover property (@(posedge mclk) disable iff (reset)
    !mode && latch ##1 !latch);
  c_level_mode: cover property (@(posedge mclk) disable iff (reset)
    mode && any_ack && !pin_level ##[1:20] !latch);
  c_irq: cover property (@(posedge mclk) disable iff (reset) irq ##1 !irq);
endmodule

// >>> core/eil_defines.svh
`ifndef EIL_DEFINES_SVH
`define EIL_DEFINES_SVH

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define EIL_STATUS_CONTROL_ADDR 12'h000
`define EIL_IRQ_STATUS_ADDR     12'h004
`define EIL_IRQ_MASK_ADDR       12'h008
`define EIL_ADDR_W              12

// ****************************************************************
// control register fields
// ****************************************************************
`define EIL_MODE_BIT    0
`define EIL_MASK_BIT    1
`define EIL_ACK_BIT     2
`define EIL_PEND_BIT    3
`define EIL_CTRL_W      4

// ****************************************************************
// interrupt status fields
// ****************************************************************
`define EIL_EV_EDGE_BIT 0
`define EIL_EV_ACK_BIT  1
`define EIL_EV_W        2

// ****************************************************************
// reset values
// ****************************************************************
`define EIL_CTRL_RESET  4'h0
`define EIL_EV_RESET    2'h0

`endif

// >>> core/eil_pkg.sv
package eil_pkg;
  `include "eil_defines.svh"

  typedef logic [`EIL_EV_W-1:0]   eil_ev_t;
  typedef logic [`EIL_ADDR_W-1:0] eil_addr_t;
  typedef logic [31:0]            eil_word_t;
endpackage

// >>> core/eil_edge_sync.sv
`timescale 1ns/1ps
module eil_edge_sync (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pin_n,
  output logic      pin_level,
  output logic      fall
);
  import eil_pkg::*;

  logic meta;
  logic sync;
  logic prev;
  // warm-up history: prev only carries a real pin sample from the third edge
  logic [2:0] warm;

  // ****************************************************************
  // two-flop synchroniser, then edge history
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
      warm <= 3'h0;
    end else begin
      meta <= pin_n;
      sync <= meta;
      prev <= sync;
      warm <= {warm[1:0], 1'b1};
    end
  end

  // high sample then low sample on the next cycle; a pin held low through
  // reset must not look like a fresh edge once reset lifts
  assign fall      = prev & ~sync & warm[2];
  assign pin_level = sync;

  property p_fall_def;
    @(posedge mclk) disable iff (reset) fall |-> $past(sync) && !sync;
  endproperty
  a_fall_def: assert property (p_fall_def)
    else $error("fall without high then low sample");
endmodule

// >>> test/eil_pin_src.sv
`timescale 1ns/1ps
module eil_pin_src (
  input  wire logic mclk,
  output logic      pin_n
);
  // pin carries a pull-up, so a released pin reads high
  initial pin_n = 1'b1;
  task automatic pull_low;
    @(posedge mclk);
    pin_n <= 1'b0;
  endtask
  task automatic release_pin;
    @(posedge mclk);
    pin_n <= 1'b1;
  endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import eil_pkg::*;
  localparam eil_addr_t A_CTL = 12'h000;
  localparam eil_addr_t A_STS = 12'h004;
  localparam eil_addr_t A_EVM = 12'h008;
  logic      mclk, reset, vfa, gmask, psel, penable, pwrite;
  logic      pin_n, req, pin_level, pready, pslverr, irq;
  eil_addr_t paddr;
  eil_word_t pwdata, prdata;
  int        n_mismatch, checked;

  eil_pin_src u_eil_pin_src (.mclk(mclk), .pin_n(pin_n));
  eil_top u_eil_top (.mclk(mclk), .reset(reset), .irq_pin_n(pin_n),
    .vector_fetch_ack(vfa), .cpu_global_mask(gmask),
    .cpu_irq_request(req), .pin_level(pin_level), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, eil_word_t seen, eil_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // entered just after an edge; one idle cycle after each transfer
  task automatic apb(logic w, eil_addr_t a, eil_word_t d,
                     output eil_word_t r, output logic e);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(eil_addr_t a, eil_word_t d);
    eil_word_t r;
    logic      e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(eil_addr_t a, eil_word_t exp, string nm);
    eil_word_t r;
    logic      e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
    chk("pslverr", {31'h0, e}, {31'h0, a > A_EVM});
  endtask
  task automatic fall;
    u_eil_pin_src.pull_low();
    cyc(6);
  endtask
  task automatic fetch;
    vfa <= 1'b1;
    @(posedge mclk);
    vfa <= 1'b0;
    cyc(2);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset_and_map;
    rd(A_CTL, 32'h0, "ctrl_reset");
    rd(A_EVM, 32'h0, "evmask_reset");
    wr(12'h00c, 32'hf);
    rd(12'h00c, 32'h0, "unmapped");
  endtask
  task automatic s_edge_fetch;
    wr(A_EVM, 32'h3);
    fall();
    chk("pin_level", {31'h0, pin_level}, 32'h0);
    u_eil_pin_src.release_pin();
    cyc(4);
    rd(A_CTL, 32'h8, "pend_edge");
    chk("req", {31'h0, req}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    fetch();
    rd(A_CTL, 32'h0, "pend_fetch");
    rd(A_STS, 32'h3, "events");
    rd(A_STS, 32'h0, "events_clr");
    chk("irq_clr", {31'h0, irq}, 32'h0);
  endtask
  task automatic s_ack_mask;
    fall();
    wr(A_CTL, 32'h4);
    rd(A_CTL, 32'h0, "pend_ack");
    u_eil_pin_src.release_pin();
    fall();
    wr(A_CTL, 32'h2);
    chk("req_masked", {31'h0, req}, 32'h0);
    rd(A_CTL, 32'ha, "pend_masked");
    wr(A_CTL, 32'h0);
    gmask <= 1'b1;
    cyc(2);
    chk("req_gmask", {31'h0, req}, 32'h0);
    gmask <= 1'b0;
    cyc(2);
    chk("req_open", {31'h0, req}, 32'h1);
    wr(A_CTL, 32'h4);
    u_eil_pin_src.release_pin();
  endtask
  task automatic s_level;
    wr(A_CTL, 32'h1);
    fall();
    wr(A_CTL, 32'h5);
    rd(A_CTL, 32'h9, "lvl_ack_low");
    u_eil_pin_src.release_pin();
    cyc(6);
    rd(A_CTL, 32'h1, "lvl_high");
    fall();
    u_eil_pin_src.release_pin();
    cyc(6);
    rd(A_CTL, 32'h9, "lvl_no_ack");
    fetch();
    rd(A_CTL, 32'h1, "lvl_fetch");
  endtask
  task automatic s_reset_low;
    fall();
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(4);
    chk("req_rst", {31'h0, req}, 32'h0);
    rd(A_CTL, 32'h0, "ctrl_rst_low");
    u_eil_pin_src.release_pin();
  endtask

  initial begin
    {reset, vfa, gmask, psel, penable, pwrite} = 6'h21;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    cyc(16);
    reset <= 1'b0;
    cyc(1);
    s_reset_and_map();
    s_edge_fetch();
    s_ack_mask();
    s_level();
    s_reset_low();
    complete_run();
  end
  initial begin
    cyc(20000);
    n_mismatch++;
    complete_run();
  end
endmodule
